// File: shared/rcl_pkg.sv
package rcl_pkg;
	// Character codes after folding to 7 bits
	localparam logic [6:0] CH_TAB = 7'h09;
	localparam logic [6:0] CH_LF = 7'h0a;
	localparam logic [6:0] CH_CR = 7'h0d;
	localparam logic [6:0] CH_SPACE = 7'h20;
	localparam logic [6:0] CH_HASH = 7'h23;
	localparam logic [6:0] CH_STAR = 7'h2a;
	localparam logic [6:0] CH_PLUS = 7'h2b;
	localparam logic [6:0] CH_COMMA = 7'h2c;
	localparam logic [6:0] CH_MINUS = 7'h2d;
	localparam logic [6:0] CH_DOT = 7'h2e;
	localparam logic [6:0] CH_SLASH = 7'h2f;
	localparam logic [6:0] CH_ZERO = 7'h30;
	localparam logic [6:0] CH_NINE = 7'h39;
	localparam logic [6:0] CH_SEMI = 7'h3b;
	localparam logic [6:0] CH_UP_A = 7'h41;
	localparam logic [6:0] CH_UP_E = 7'h45;
	localparam logic [6:0] CH_UP_Z = 7'h5a;
	localparam logic [6:0] CH_LO_A = 7'h61;
	localparam logic [6:0] CH_LO_Z = 7'h7a;
	localparam logic [6:0] CH_CASE_BIT = 7'h20;
	// Raw byte codes for block data and responses
	localparam logic [7:0] BYTE_LF = 8'h0a;
	localparam logic [7:0] BYTE_CR = 8'h0d;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Number limits
	localparam logic [4:0] MAX_SIG_DIGITS = 5'h0f;
	localparam logic [7:0] MAX_EXP_MAG = 8'h14;
	localparam logic [2:0] UNIT_MAX_LEN = 3'h4;
	localparam int BLK_CNT_MIN_W = 30;

	typedef enum logic {RCL_LINK_PARALLEL, RCL_LINK_SERIAL} rcl_link_t;
	typedef enum logic [1:0] {RCL_EOL_CR, RCL_EOL_LF, RCL_EOL_CRLF} rcl_eol_t;
	typedef enum logic [2:0] {
		ERR_NONE, ERR_COUNT, ERR_NULL, ERR_EXPR, ERR_NUMBER, ERR_SPACE, ERR_BLOCK
	} rcl_err_t;
	typedef enum logic [4:0] {
		U_NONE, U_HZ, U_KHZ, U_MHZ, U_UV, U_MV, U_V, U_KV, U_UA, U_MA, U_A, U_PCT,
		U_PPM, U_DBM, U_OHM, U_KOHM, U_MOHM, U_NF, U_PF, U_UF, U_MF, U_F, U_CEL,
		U_FAR, U_NS, U_US, U_MS, U_S
	} rcl_unit_t;
	typedef enum logic [3:0] {
		S_KW, S_GAP, S_PARAM, S_PTAIL, S_HASH, S_DIGITS, S_DEF, S_INDEF, S_DISCARD
	} rcl_state_t;
	typedef enum logic [1:0] {RT_PASS, RT_TERM, RT_TAIL} rcl_rt_state_t;
endpackage

// File: src/rcl_unit_match.sv
`timescale 1ns/1ps
module rcl_unit_match (
	input wire logic [31:0] chars_in,
	input wire logic [2:0] len_in,
	output rcl_pkg::rcl_unit_t unit_out,
	output logic hit_out
);
	// Chars are upper case, right aligned, zero filled on the left
	function automatic rcl_pkg::rcl_unit_t lookup(input logic [31:0] s);
		unique case (s)
			32'("HZ"): lookup = rcl_pkg::U_HZ;
			32'("KHZ"): lookup = rcl_pkg::U_KHZ;
			32'("MHZ"): lookup = rcl_pkg::U_MHZ;
			32'("UV"): lookup = rcl_pkg::U_UV;
			32'("MV"): lookup = rcl_pkg::U_MV;
			32'("V"): lookup = rcl_pkg::U_V;
			32'("KV"): lookup = rcl_pkg::U_KV;
			32'("UA"): lookup = rcl_pkg::U_UA;
			32'("MA"): lookup = rcl_pkg::U_MA;
			32'("A"): lookup = rcl_pkg::U_A;
			32'("PCT"): lookup = rcl_pkg::U_PCT;
			32'("PPM"): lookup = rcl_pkg::U_PPM;
			32'("DBM"): lookup = rcl_pkg::U_DBM;
			32'("OHM"): lookup = rcl_pkg::U_OHM;
			"KOHM": lookup = rcl_pkg::U_KOHM;
			"MOHM": lookup = rcl_pkg::U_MOHM;
			32'("NF"): lookup = rcl_pkg::U_NF;
			32'("PF"): lookup = rcl_pkg::U_PF;
			32'("UF"): lookup = rcl_pkg::U_UF;
			32'("MF"): lookup = rcl_pkg::U_MF;
			32'("F"): lookup = rcl_pkg::U_F;
			32'("CEL"): lookup = rcl_pkg::U_CEL;
			32'("FAR"): lookup = rcl_pkg::U_FAR;
			32'("NS"): lookup = rcl_pkg::U_NS;
			32'("US"): lookup = rcl_pkg::U_US;
			32'("MS"): lookup = rcl_pkg::U_MS;
			32'("S"): lookup = rcl_pkg::U_S;
			default: lookup = rcl_pkg::U_NONE;
		endcase
	endfunction

	// Over-long suffix never matches, even if its last four letters would
	always_comb begin
		unit_out = (len_in <= rcl_pkg::UNIT_MAX_LEN) ? lookup(chars_in) : rcl_pkg::U_NONE;
		hit_out = unit_out != rcl_pkg::U_NONE;
	end
endmodule // rcl_unit_match

// File: src/rcl_resp_tx.sv
`timescale 1ns/1ps
module rcl_resp_tx (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire rcl_pkg::rcl_link_t link_sel_in,
	input wire rcl_pkg::rcl_eol_t eol_sel_in,
	input wire logic [7:0] resp_byte_in,
	input wire logic resp_valid_in,
	input wire logic resp_last_in,
	output logic resp_ready_out,
	input wire logic tx_ready_in,
	output logic [7:0] tx_byte_out,
	output logic tx_valid_out,
	output logic tx_eoi_out
);
	rcl_pkg::rcl_rt_state_t rt_reg;
	logic slot_free;

	assign slot_free = !tx_valid_out || tx_ready_in;
	assign resp_ready_out = slot_free && rt_reg == rcl_pkg::RT_PASS;

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			rt_reg <= rcl_pkg::RT_PASS;
		end else if (slot_free) begin
			unique case (rt_reg)
				rcl_pkg::RT_PASS: if (resp_valid_in && resp_last_in) rt_reg <= rcl_pkg::RT_TERM;
				rcl_pkg::RT_TERM: begin
					if (link_sel_in == rcl_pkg::RCL_LINK_SERIAL &&
						eol_sel_in == rcl_pkg::RCL_EOL_CRLF) begin
						rt_reg <= rcl_pkg::RT_TAIL;
					end else begin
						rt_reg <= rcl_pkg::RT_PASS;
					end
				end
				rcl_pkg::RT_TAIL: rt_reg <= rcl_pkg::RT_PASS;
			endcase
		end
	end

	// Output slot holds one byte; upstream stalls while it is full
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			tx_byte_out <= rcl_pkg::BYTE_ZERO;
			tx_valid_out <= 1'b0;
			tx_eoi_out <= 1'b0;
		end else if (slot_free) begin
			tx_valid_out <= 1'b0;
			tx_eoi_out <= 1'b0;
			unique case (rt_reg)
				rcl_pkg::RT_PASS: begin
					if (resp_valid_in) begin
						tx_byte_out <= resp_byte_in;
						tx_valid_out <= 1'b1;
					end
				end
				rcl_pkg::RT_TERM: begin
					tx_valid_out <= 1'b1;
					if (link_sel_in == rcl_pkg::RCL_LINK_PARALLEL) begin
						tx_byte_out <= rcl_pkg::BYTE_LF;
						tx_eoi_out <= 1'b1;
					end else begin
						unique case (eol_sel_in)
							rcl_pkg::RCL_EOL_CR: tx_byte_out <= rcl_pkg::BYTE_CR;
							rcl_pkg::RCL_EOL_CRLF: tx_byte_out <= rcl_pkg::BYTE_CR;
							default: tx_byte_out <= rcl_pkg::BYTE_LF;
						endcase
					end
				end
				rcl_pkg::RT_TAIL: begin
					tx_byte_out <= rcl_pkg::BYTE_LF;
					tx_valid_out <= 1'b1;
				end
			endcase
		end
	end
endmodule // rcl_resp_tx

// File: src/rcl_lexer.sv
// How it works
// - Keywords and units match regardless of case
// - Recognise the fixed scaled unit suffix vocabulary
// - Numbers: fifteen significant digits, exponent to twenty
// - Wrong parameter count raises a command error
// - Empty parameter between separators is an error
// - Arithmetic expressions as parameters are rejected
// - Indefinite block ends on parallel LF with EOI, serial CR or LF
// - Definite count digits must be codes 48-57
// - Definite block carries exactly the counted bytes
// - Skip blanks between parameters, refuse inside them except before a unit
// - Terminator codes: CR 13, LF 10
// - Parallel responses end with LF plus EOI
// - Parallel input ends on LF or EOI
// - Serial responses end with CR, LF or CRLF
// - Outside blocks, drop the top data bit
// - Discard control codes except LF, serial CR, user data
// - Block bytes pass unfiltered to their own end
// - Semicolon splits a line into separate commands
`timescale 1ns/1ps
module rcl_lexer #(
	parameter int BLK_CNT_W = 32,
	parameter int PCNT_W = 4
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] rx_byte_in,
	input wire logic rx_valid_in,
	input wire logic rx_eoi_in,
	input wire rcl_pkg::rcl_link_t link_sel_in,
	input wire rcl_pkg::rcl_eol_t eol_sel_in,
	input wire logic [PCNT_W-1:0] param_expect_in,
	input wire logic user_data_cmd_in,
	input wire logic err_clear_in,
	output logic [7:0] tok_char_out,
	output logic tok_valid_out,
	output logic tok_in_param_out,
	output logic param_end_out,
	output rcl_pkg::rcl_unit_t unit_code_out,
	output logic cmd_end_out,
	output logic msg_end_out,
	output logic [7:0] blk_byte_out,
	output logic blk_valid_out,
	output logic blk_end_out,
	output logic err_out,
	output rcl_pkg::rcl_err_t err_code_out,
	input wire logic [7:0] resp_byte_in,
	input wire logic resp_valid_in,
	input wire logic resp_last_in,
	output logic resp_ready_out,
	input wire logic tx_ready_in,
	output logic [7:0] tx_byte_out,
	output logic tx_valid_out,
	output logic tx_eoi_out
);
	generate
		if (BLK_CNT_W < rcl_pkg::BLK_CNT_MIN_W || PCNT_W < 1) begin : g_bad_width
			$error("rcl_lexer: BLK_CNT_W must hold nine decimal digits");
		end
	endgenerate

	rcl_pkg::rcl_state_t state_reg, state_next;
	logic kw_seen_reg, kw_seen_next;
	logic comma_pend_reg, comma_pend_next;
	logic [PCNT_W-1:0] param_cnt_reg, param_cnt_next;
	logic num_reg, num_next;
	logic sig_started_reg, sig_started_next;
	logic [4:0] sig_cnt_reg, sig_cnt_next;
	logic mant_dig_reg, mant_dig_next;
	logic in_exp_reg, in_exp_next;
	logic exp_sign_reg, exp_sign_next;
	logic exp_dig_reg, exp_dig_next;
	logic [7:0] exp_val_reg, exp_val_next;
	logic [31:0] unit_sh_reg, unit_sh_next;
	logic [2:0] unit_len_reg, unit_len_next;
	logic [3:0] blk_ndig_reg, blk_ndig_next;
	logic [BLK_CNT_W-1:0] blk_cnt_reg, blk_cnt_next;

	logic [6:0] c7, up;
	logic [3:0] dval;
	logic [7:0] exp_calc;
	logic [BLK_CNT_W-1:0] cnt_calc;
	logic is_digit, is_letter, is_space, is_term, blk_term, in_arg, drop;
	logic do_end, end_msg, fin, first, param_bad;
	logic ev_tok, ev_param_end, ev_blk, ev_blk_end, err_hit;
	rcl_pkg::rcl_err_t err_kind;
	rcl_pkg::rcl_unit_t unit_code;
	logic unit_hit;

	rcl_unit_match u_unit (
		.chars_in(unit_sh_reg),
		.len_in(unit_len_reg),
		.unit_out(unit_code),
		.hit_out(unit_hit)
	);

	rcl_resp_tx u_resp (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.link_sel_in(link_sel_in),
		.eol_sel_in(eol_sel_in),
		.resp_byte_in(resp_byte_in),
		.resp_valid_in(resp_valid_in),
		.resp_last_in(resp_last_in),
		.resp_ready_out(resp_ready_out),
		.tx_ready_in(tx_ready_in),
		.tx_byte_out(tx_byte_out),
		.tx_valid_out(tx_valid_out),
		.tx_eoi_out(tx_eoi_out)
	);

	// A finished numeric parameter must be complete and any unit must be a known one
	assign param_bad = num_reg && (!mant_dig_reg || (in_exp_reg && !exp_dig_reg) ||
		exp_val_reg > rcl_pkg::MAX_EXP_MAG || (unit_len_reg != 3'h0 && !unit_hit));

	always_comb begin
		c7 = rx_byte_in[6:0];
		up = (c7 >= rcl_pkg::CH_LO_A && c7 <= rcl_pkg::CH_LO_Z) ?
			(c7 & ~rcl_pkg::CH_CASE_BIT) : c7;
		dval = up[3:0];
		is_digit = up >= rcl_pkg::CH_ZERO && up <= rcl_pkg::CH_NINE;
		is_letter = up >= rcl_pkg::CH_UP_A && up <= rcl_pkg::CH_UP_Z;
		is_space = up == rcl_pkg::CH_SPACE || up == rcl_pkg::CH_TAB;
		if (link_sel_in == rcl_pkg::RCL_LINK_PARALLEL) begin
			is_term = c7 == rcl_pkg::CH_LF || rx_eoi_in;
			blk_term = rx_byte_in == rcl_pkg::BYTE_LF && rx_eoi_in;
		end else begin
			is_term = c7 == rcl_pkg::CH_LF || c7 == rcl_pkg::CH_CR;
			blk_term = rx_byte_in == rcl_pkg::BYTE_LF || rx_byte_in == rcl_pkg::BYTE_CR;
		end
		in_arg = state_reg == rcl_pkg::S_GAP || state_reg == rcl_pkg::S_PARAM ||
			state_reg == rcl_pkg::S_PTAIL;
		drop = c7 < rcl_pkg::CH_SPACE && !(user_data_cmd_in && in_arg);

		state_next = state_reg;
		kw_seen_next = kw_seen_reg;
		comma_pend_next = comma_pend_reg;
		param_cnt_next = param_cnt_reg;
		num_next = num_reg;
		sig_started_next = sig_started_reg;
		sig_cnt_next = sig_cnt_reg;
		mant_dig_next = mant_dig_reg;
		in_exp_next = in_exp_reg;
		exp_sign_next = exp_sign_reg;
		exp_dig_next = exp_dig_reg;
		exp_val_next = exp_val_reg;
		unit_sh_next = unit_sh_reg;
		unit_len_next = unit_len_reg;
		blk_ndig_next = blk_ndig_reg;
		blk_cnt_next = blk_cnt_reg;
		do_end = 1'b0;
		end_msg = 1'b0;
		fin = 1'b0;
		first = 1'b0;
		ev_tok = 1'b0;
		ev_param_end = 1'b0;
		ev_blk = 1'b0;
		ev_blk_end = 1'b0;
		err_hit = 1'b0;
		err_kind = rcl_pkg::ERR_NONE;
		exp_calc = 8'(exp_val_reg * 8'h0a + {4'h0, dval});
		cnt_calc = BLK_CNT_W'((blk_cnt_reg << 3) + (blk_cnt_reg << 1) +
			{{(BLK_CNT_W-4){1'b0}}, dval});

		if (rx_valid_in) begin
			if (state_reg == rcl_pkg::S_DEF) begin
				ev_blk = 1'b1;
				blk_cnt_next = blk_cnt_reg - 1'b1;
				if (blk_cnt_reg == {{(BLK_CNT_W-1){1'b0}}, 1'b1}) begin
					ev_blk_end = 1'b1;
					state_next = rcl_pkg::S_PTAIL;
				end
			end else if (state_reg == rcl_pkg::S_INDEF) begin
				if (blk_term) begin
					ev_blk_end = 1'b1;
					do_end = 1'b1;
					end_msg = 1'b1;
				end else begin
					ev_blk = 1'b1;
				end
			end else if (is_term) begin
				do_end = 1'b1;
				end_msg = 1'b1;
			end else if (!drop) begin
				if (up == rcl_pkg::CH_SEMI) begin
					do_end = 1'b1;
				end else begin
					unique case (state_reg)
						rcl_pkg::S_KW: begin
							if (is_space) begin
								if (kw_seen_reg) state_next = rcl_pkg::S_GAP;
							end else begin
								kw_seen_next = 1'b1;
								ev_tok = 1'b1;
							end
						end
						rcl_pkg::S_GAP: begin
							if (up == rcl_pkg::CH_COMMA) begin
								err_hit = 1'b1;
								err_kind = rcl_pkg::ERR_NULL;
							end else if (!is_space) begin
								first = 1'b1;
							end
						end
						rcl_pkg::S_PARAM: begin
							if (is_space) state_next = rcl_pkg::S_PTAIL;
							else if (up == rcl_pkg::CH_COMMA) fin = 1'b1;
							else ev_tok = 1'b1;
						end
						rcl_pkg::S_PTAIL: begin
							if (up == rcl_pkg::CH_COMMA) begin
								fin = 1'b1;
							end else if (is_letter && num_reg && unit_len_reg == 3'h0) begin
								state_next = rcl_pkg::S_PARAM;
								ev_tok = 1'b1;
							end else if (!is_space) begin
								err_hit = 1'b1;
								err_kind = rcl_pkg::ERR_SPACE;
							end
						end
						rcl_pkg::S_HASH: begin
							if (up == rcl_pkg::CH_ZERO) begin
								state_next = rcl_pkg::S_INDEF;
							end else if (is_digit) begin
								blk_ndig_next = dval;
								blk_cnt_next = '0;
								state_next = rcl_pkg::S_DIGITS;
							end else begin
								err_hit = 1'b1;
								err_kind = rcl_pkg::ERR_BLOCK;
							end
						end
						rcl_pkg::S_DIGITS: begin
							if (is_digit) begin
								blk_cnt_next = cnt_calc;
								blk_ndig_next = blk_ndig_reg - 1'b1;
								if (blk_ndig_reg == 4'h1) begin
									state_next = (cnt_calc == '0) ? rcl_pkg::S_PTAIL : rcl_pkg::S_DEF;
								end
							end else begin
								err_hit = 1'b1;
								err_kind = rcl_pkg::ERR_BLOCK;
							end
						end
						default: ;
					endcase
				end
			end
		end

		// Start of a parameter clears its number tracking
		if (first) begin
			comma_pend_next = 1'b0;
			state_next = rcl_pkg::S_PARAM;
			num_next = is_digit || up == rcl_pkg::CH_DOT || up == rcl_pkg::CH_PLUS ||
				up == rcl_pkg::CH_MINUS;
			sig_started_next = 1'b0;
			sig_cnt_next = 5'h00;
			mant_dig_next = 1'b0;
			in_exp_next = 1'b0;
			exp_sign_next = 1'b0;
			exp_dig_next = 1'b0;
			exp_val_next = 8'h00;
			unit_sh_next = 32'h0000_0000;
			unit_len_next = 3'h0;
			if (up == rcl_pkg::CH_HASH) state_next = rcl_pkg::S_HASH;
			else ev_tok = 1'b1;
			exp_calc = {4'h0, dval};
		end

		// Number grammar, applied to every character of a numeric parameter
		if (ev_tok && state_next == rcl_pkg::S_PARAM && num_next) begin
			if (is_digit) begin
				if (in_exp_next) begin
					exp_dig_next = 1'b1;
					exp_val_next = (exp_calc > rcl_pkg::MAX_EXP_MAG) ?
						rcl_pkg::MAX_EXP_MAG + 8'h01 : exp_calc;
				end else if (unit_len_next != 3'h0) begin
					err_hit = 1'b1;
					err_kind = rcl_pkg::ERR_NUMBER;
				end else begin
					mant_dig_next = 1'b1;
					if (dval != 4'h0 || sig_started_next) begin
						sig_started_next = 1'b1;
						if (sig_cnt_next == rcl_pkg::MAX_SIG_DIGITS) begin
							err_hit = 1'b1;
							err_kind = rcl_pkg::ERR_NUMBER;
						end else begin
							sig_cnt_next = sig_cnt_next + 5'h01;
						end
					end
				end
			end else if (up == rcl_pkg::CH_DOT && !in_exp_next && unit_len_next == 3'h0) begin
				mant_dig_next = mant_dig_next;
			end else if (up == rcl_pkg::CH_UP_E && !in_exp_next && unit_len_next == 3'h0 &&
				mant_dig_next) begin
				in_exp_next = 1'b1;
			end else if (up == rcl_pkg::CH_PLUS || up == rcl_pkg::CH_MINUS) begin
				if (in_exp_next && !exp_dig_next && !exp_sign_next) begin
					exp_sign_next = 1'b1;
				end else if (!first) begin
					err_hit = 1'b1;
					err_kind = rcl_pkg::ERR_EXPR;
				end
			end else if (up == rcl_pkg::CH_STAR || up == rcl_pkg::CH_SLASH) begin
				err_hit = 1'b1;
				err_kind = rcl_pkg::ERR_EXPR;
			end else if (is_letter && !(in_exp_next && !exp_dig_next)) begin
				unit_sh_next = {unit_sh_next[23:0], 1'b0, up};
				if (unit_len_next <= rcl_pkg::UNIT_MAX_LEN) unit_len_next = unit_len_next + 3'h1;
			end else begin
				err_hit = 1'b1;
				err_kind = rcl_pkg::ERR_NUMBER;
			end
		end

		if (do_end && (state_reg == rcl_pkg::S_PARAM || state_reg == rcl_pkg::S_PTAIL ||
			state_reg == rcl_pkg::S_INDEF)) begin
			fin = 1'b1;
		end
		if (fin) begin
			if (param_bad) begin
				err_hit = 1'b1;
				err_kind = rcl_pkg::ERR_NUMBER;
			end else begin
				ev_param_end = 1'b1;
				param_cnt_next = PCNT_W'(param_cnt_reg + 1'b1);
			end
			if (!do_end) begin
				comma_pend_next = 1'b1;
				state_next = rcl_pkg::S_GAP;
			end
		end

		if (do_end) begin
			if (state_reg != rcl_pkg::S_DISCARD && !err_hit) begin
				if (state_reg == rcl_pkg::S_GAP && comma_pend_reg) begin
					err_hit = 1'b1;
					err_kind = rcl_pkg::ERR_NULL;
				end else if (state_reg == rcl_pkg::S_HASH || state_reg == rcl_pkg::S_DIGITS) begin
					err_hit = 1'b1;
					err_kind = rcl_pkg::ERR_BLOCK;
				end else if (kw_seen_reg && param_cnt_next != param_expect_in) begin
					err_hit = 1'b1;
					err_kind = rcl_pkg::ERR_COUNT;
				end
			end
			state_next = rcl_pkg::S_KW;
			kw_seen_next = 1'b0;
			comma_pend_next = 1'b0;
			param_cnt_next = '0;
		end else if (err_hit) begin
			state_next = rcl_pkg::S_DISCARD;
		end
		if (err_hit) ev_tok = 1'b0;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			state_reg <= rcl_pkg::S_KW;
			kw_seen_reg <= 1'b0;
			comma_pend_reg <= 1'b0;
			param_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			kw_seen_reg <= kw_seen_next;
			comma_pend_reg <= comma_pend_next;
			param_cnt_reg <= param_cnt_next;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			num_reg <= 1'b0;
			sig_started_reg <= 1'b0;
			sig_cnt_reg <= 5'h00;
			mant_dig_reg <= 1'b0;
			in_exp_reg <= 1'b0;
			exp_sign_reg <= 1'b0;
			exp_dig_reg <= 1'b0;
			exp_val_reg <= 8'h00;
			unit_sh_reg <= 32'h0000_0000;
			unit_len_reg <= 3'h0;
		end else begin
			num_reg <= num_next;
			sig_started_reg <= sig_started_next;
			sig_cnt_reg <= sig_cnt_next;
			mant_dig_reg <= mant_dig_next;
			in_exp_reg <= in_exp_next;
			exp_sign_reg <= exp_sign_next;
			exp_dig_reg <= exp_dig_next;
			exp_val_reg <= exp_val_next;
			unit_sh_reg <= unit_sh_next;
			unit_len_reg <= unit_len_next;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			blk_ndig_reg <= 4'h0;
			blk_cnt_reg <= '0;
		end else begin
			blk_ndig_reg <= blk_ndig_next;
			blk_cnt_reg <= blk_cnt_next;
		end
	end

	// Event outputs are registered one cycle after the byte is taken
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			tok_char_out <= rcl_pkg::BYTE_ZERO;
			tok_valid_out <= 1'b0;
			tok_in_param_out <= 1'b0;
			param_end_out <= 1'b0;
			unit_code_out <= rcl_pkg::U_NONE;
			cmd_end_out <= 1'b0;
			msg_end_out <= 1'b0;
			blk_byte_out <= rcl_pkg::BYTE_ZERO;
			blk_valid_out <= 1'b0;
			blk_end_out <= 1'b0;
		end else begin
			tok_valid_out <= ev_tok;
			if (ev_tok) begin
				tok_char_out <= {1'b0, up};
				tok_in_param_out <= state_next != rcl_pkg::S_KW;
			end
			param_end_out <= ev_param_end;
			if (ev_param_end) unit_code_out <= num_reg ? unit_code : rcl_pkg::U_NONE;
			cmd_end_out <= do_end;
			msg_end_out <= end_msg;
			blk_valid_out <= ev_blk;
			if (ev_blk) blk_byte_out <= rx_byte_in;
			blk_end_out <= ev_blk_end;
		end
	end

	// A new error in the clear cycle wins over the clear
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			err_out <= 1'b0;
			err_code_out <= rcl_pkg::ERR_NONE;
		end else if (err_hit) begin
			err_out <= 1'b1;
			if (!err_out || err_clear_in) err_code_out <= err_kind;
		end else if (err_clear_in) begin
			err_out <= 1'b0;
			err_code_out <= rcl_pkg::ERR_NONE;
		end
	end
endmodule // rcl_lexer

// File: tb/rcl_host_model.sv
`timescale 1ns/1ps
module rcl_host_model (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_valid_in,
	input wire logic tx_eoi_in,
	output logic tx_ready_out
);
	logic [1:0] stall_reg;
	logic [8:0] got_q[$];
	// Slow host: refuses one cycle in four
	assign tx_ready_out = stall_reg != 2'h0;
	always @(posedge ref_clk_in) begin
		stall_reg <= rstn_in ? stall_reg + 2'h1 : 2'h0;
		if (rstn_in && tx_valid_in && tx_ready_out)
			got_q.push_back({tx_eoi_in, tx_byte_in});
	end
endmodule // rcl_host_model

// File: tb/rcl_lexer_monitor.sv
`timescale 1ns/1ps
module rcl_lexer_monitor (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic rx_valid_in,
	input wire logic rx_eoi_in,
	input wire rcl_pkg::rcl_link_t link_sel_in,
	input wire logic user_data_cmd_in,
	input wire logic err_clear_in,
	input wire logic [7:0] tok_char_out,
	input wire logic tok_valid_out,
	input wire logic cmd_end_out,
	input wire logic msg_end_out,
	input wire logic blk_end_out,
	input wire logic err_out,
	input wire logic tx_ready_in,
	input wire logic [7:0] tx_byte_out,
	input wire logic tx_valid_out,
	input wire logic tx_eoi_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	property p_eoi_lf; tx_valid_out && tx_eoi_out |-> tx_byte_out == rcl_pkg::BYTE_LF; endproperty
	a_eoi_lf: assert property (p_eoi_lf) else $error("eoi on non line feed");
	property p_ser_eoi; tx_valid_out && link_sel_in == rcl_pkg::RCL_LINK_SERIAL |-> !tx_eoi_out;
	endproperty
	a_ser_eoi: assert property (p_ser_eoi) else $error("eoi on serial link");
	property p_tx_hold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
	property p_tok_7b; tok_valid_out |-> !tok_char_out[7] && !(tok_char_out inside {[8'h61:8'h7a]});
	endproperty
	a_tok_7b: assert property (p_tok_7b) else $error("token not folded");
	property p_ctrl; tok_valid_out && !$past(user_data_cmd_in) |-> tok_char_out[6:5] != 2'h0;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control code tokenised");
	property p_eoi_term;
		rx_valid_in && rx_eoi_in && link_sel_in == rcl_pkg::RCL_LINK_PARALLEL && tok_valid_out
			|=> msg_end_out;
	endproperty
	a_eoi_term: assert property (p_eoi_term) else $error("eoi byte did not end");
	property p_msg_cmd; msg_end_out && !blk_end_out |-> cmd_end_out; endproperty
	a_msg_cmd: assert property (p_msg_cmd) else $error("msg end without cmd end");
	property p_err_stick; err_out && !err_clear_in |=> err_out; endproperty
	a_err_stick: assert property (p_err_stick) else $error("error flag lost");
endmodule // rcl_lexer_monitor
bind rcl_lexer rcl_lexer_monitor u_mon (.*);

// File: tb/rcl_lexer_tb.sv
`timescale 1ns/1ps
module rcl_lexer_tb;
	logic ref_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] rx_byte_in = 8'h00;
	logic rx_valid_in = 1'b0;
	logic rx_eoi_in = 1'b0;
	rcl_pkg::rcl_link_t link_sel_in = rcl_pkg::RCL_LINK_PARALLEL;
	rcl_pkg::rcl_eol_t eol_sel_in = rcl_pkg::RCL_EOL_CR;
	logic [3:0] param_expect_in = 4'h1;
	logic user_data_cmd_in = 1'b0;
	logic err_clear_in = 1'b0;
	logic [7:0] resp_byte_in = 8'h00;
	logic resp_valid_in = 1'b0;
	logic resp_last_in = 1'b0;
	logic tx_ready_in, resp_ready_out, tok_valid_out, param_end_out, cmd_end_out, msg_end_out;
	logic blk_valid_out, blk_end_out, err_out, tx_valid_out, tx_eoi_out, tok_in_param_out;
	logic [7:0] tok_char_out, blk_byte_out, tx_byte_out;
	rcl_pkg::rcl_unit_t unit_code_out;
	rcl_pkg::rcl_err_t err_code_out;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_msg, n_cmd, n_blk, n_prm, n_pe;
	string ts, bs;
	rcl_lexer u_dut (.*);
	rcl_host_model u_host (.ref_clk_in, .rstn_in, .tx_byte_in(tx_byte_out),
		.tx_valid_in(tx_valid_out), .tx_eoi_in(tx_eoi_out), .tx_ready_out(tx_ready_in));
	initial forever #25 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (tok_valid_out === 1'b1) ts = {ts, string'(tok_char_out)};
		if (blk_valid_out === 1'b1) bs = {bs, string'(blk_byte_out)};
		n_msg += msg_end_out;
		n_cmd += cmd_end_out;
		n_blk += blk_end_out;
		n_prm += tok_valid_out && tok_in_param_out;
		n_pe += param_end_out;
		// Run needs under 2000 cycles
		if (cyc == 8000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic put(logic [7:0] b, logic e = 1'b0);
		@(posedge ref_clk_in);
		rx_byte_in <= b;
		rx_valid_in <= 1'b1;
		rx_eoi_in <= e;
	endtask
	task automatic say(string s);
		foreach (s[i]) put(s[i]);
	endtask
	task automatic fin(logic [7:0] b = 8'h0a, logic e = 1'b1);
		put(b, e);
		@(posedge ref_clk_in);
		rx_valid_in <= 1'b0;
		rx_eoi_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
	endtask
	task automatic start(logic [3:0] n);
		param_expect_in <= n;
		ts = "";
		bs = "";
		{n_msg, n_cmd, n_blk, n_prm, n_pe} = '0;
	endtask
	task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic cmps(string what, string exp, string got);
		n_checks++;
		if (got != exp) begin
			fail_count++;
			$display("ERROR %s expected %s seen %s", what, exp, got);
		end
	endtask
	task automatic t_chars;
		start(4'h1);
		put(8'hef);
		say("ut");
		put(8'h01);
		say(" 1 v");
		fin();
		cmps("tokens", "OUT1V", ts);
		cmp("unit", rcl_pkg::U_V, unit_code_out);
		cmp("msg end", 1, n_msg);
		cmp("param toks", 2, n_prm);
		cmp("param ends", 1, n_pe);
		start(4'h1);
		user_data_cmd_in <= 1'b1;
		say("P x");
		put(8'h07);
		fin();
		user_data_cmd_in <= 1'b0;
		cmps("user data", "PX\007", ts);
		$display("t_chars done");
	endtask
	task automatic t_units;
		string us[5] = '{"khz", "MHz", "mv", "PPM", "kohm"};
		rcl_pkg::rcl_unit_t ue[5] = '{rcl_pkg::U_KHZ, rcl_pkg::U_MHZ, rcl_pkg::U_MV,
			rcl_pkg::U_PPM, rcl_pkg::U_KOHM};
		foreach (us[i]) begin
			start(4'h1);
			say({"A 2", us[i]});
			fin();
			cmp("unit", ue[i], unit_code_out);
		end
		$display("t_units done");
	endtask
	task automatic t_errs;
		string cs[8] = '{"A 1", "A 1,2", "A 1,,2", "A 4+2", "A 1234567890123456", "A 1E21",
			"A 123456789012345E-20", "D #1A"};
		logic [3:0] ns[8] = '{4'h2, 4'h1, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
		rcl_pkg::rcl_err_t es[8] = '{rcl_pkg::ERR_COUNT, rcl_pkg::ERR_COUNT, rcl_pkg::ERR_NULL,
			rcl_pkg::ERR_EXPR, rcl_pkg::ERR_NUMBER, rcl_pkg::ERR_NUMBER, rcl_pkg::ERR_NONE,
			rcl_pkg::ERR_BLOCK};
		foreach (cs[i]) begin
			start(ns[i]);
			say(cs[i]);
			fin();
			cmp("err code", es[i], err_code_out);
			cmp("err flag", es[i] != rcl_pkg::ERR_NONE, err_out);
			err_clear_in <= 1'b1;
			@(posedge ref_clk_in);
			err_clear_in <= 1'b0;
		end
		$display("t_errs done");
	endtask
	task automatic t_semi;
		start(4'h0);
		say("A;b");
		fin(8'h0d);
		cmps("tokens", "AB", ts);
		cmp("cmd ends", 2, n_cmd);
		cmp("msg ends", 1, n_msg);
		$display("t_semi done");
	endtask
	task automatic t_blocks;
		start(4'h1);
		say("D #0");
		put(8'h0a);
		put(8'h1b);
		fin();
		cmps("par block", "\012\033", bs);
		cmp("par block end", 1, n_blk);
		start(4'h1);
		say("D #13");
		put(8'h0a);
		put(8'h8d);
		put(8'h3b);
		fin();
		cmps("def block", "\012\215;", bs);
		cmp("def msg end", 1, n_msg);
		start(4'h1);
		link_sel_in <= rcl_pkg::RCL_LINK_SERIAL;
		say("D #0");
		put(8'h01);
		put(8'h8a);
		fin(8'h0d, 1'b0);
		cmps("ser block", "\001\212", bs);
		cmp("ser msg end", 1, n_msg);
		$display("t_blocks done");
	endtask
	task automatic t_resp;
		logic [8:0] e[$];
		for (int k = 0; k < 4; k++) begin
			e = '{9'h041, 9'h042};
			if (k == 3) e.push_back(9'h10a);
			if (k == 0 || k == 2) e.push_back(9'h00d);
			if (k == 1 || k == 2) e.push_back(9'h00a);
			@(posedge ref_clk_in);
			link_sel_in <= k == 3 ? rcl_pkg::RCL_LINK_PARALLEL : rcl_pkg::RCL_LINK_SERIAL;
			eol_sel_in <= rcl_pkg::rcl_eol_t'(k[1:0]);
			u_host.got_q.delete();
			for (int i = 0; i < 2; i++) begin
				resp_byte_in <= 8'h41 + 8'(i);
				resp_valid_in <= 1'b1;
				resp_last_in <= i == 1;
				do @(posedge ref_clk_in); while (resp_ready_out !== 1'b1);
			end
			resp_valid_in <= 1'b0;
			repeat (12) @(posedge ref_clk_in);
			cmp("tx count", e.size(), u_host.got_q.size());
			foreach (e[j]) cmp("tx byte", e[j], u_host.got_q[j]);
		end
		$display("t_resp done");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		t_chars();
		t_units();
		t_errs();
		t_semi();
		t_blocks();
		t_resp();
		stop_test();
	end
endmodule // rcl_lexer_tb
